// ===== src/ums_top.sv
// modem status register, shared scratch register and baud generator
// with its divisor latches, for the uart side of a modem device.
// assumes: all inputs synchronous to clock; control bits come from the
// surrounding uart registers; ref_tick pulses at the reference rate.
//
// Overview of operation
// RULE1: line states from internal control bits, or inverted pins when standalone.
// RULE2: change flags record any line change since last status read; read clears.
// RULE3: loop mode feeds cts, dsr, ri, dcd from rts, dtr, reset, int enable.
// RULE4: status bit 0 flags a clear-to-send change since last read.
// RULE5: status bit 1 flags a data-set-ready change since last read.
// RULE6: status bit 2 flags a ring-indicator change.
// RULE7: status bit 3 flags a carrier-detect change.
// RULE8: status bits 4..7 show cts, dsr, ri, dcd line states.
// RULE9: status register is read only; host writes leave it unchanged.
// RULE10: scratch at address 7 reachable from host bus and modem bus alike.
// RULE11: scratch keeps the value of whichever write came last.
// RULE12: with divisor access set, address 0 is divisor low, 1 divisor high.
// RULE13: divisor kept in two write-only 8-bit registers.
// RULE14: baud output divides the reference tick by the 16-bit divisor.
// RULE15: baud output runs at sixteen times the serial data rate.
// RULE16: baud output reaches its pin only while the pin enable bit is set.
// RULE17: writing either divisor byte reloads the down-counter at once.
// RULE18: software uses 384 for 300, 96 for 1200, 2304 for 50 bit/s.
// RULE19: loop mode ignores external line pins and forces control outputs off.
// RULE20: a change arriving with a status read keeps its flag set.
`timescale 1ns/1ns
module ums_top
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // host uart bus
  input wire logic [2:0] uart_address_lines,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  // modem controller bus, scratch only
  input wire logic mdm_scr_rd,
  input wire logic mdm_scr_wr,
  input wire logic [7:0] mdm_wdata,
  output logic [7:0] mdm_rdata,
  // uart control bits
  input wire logic divisor_access_bit,
  input wire logic standalone_select,
  input wire logic loop_mode,
  input wire logic [3:0] line_control_outputs,
  input wire logic [3:0] internal_line_bits,
  input wire logic baud_pin_enable,
  // external line pins, active low
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic ri_n,
  input wire logic dcd_n,
  output logic [3:0] ctl_out_n,
  // baud generator
  input wire logic ref_tick,
  output logic baud_tick16,
  output logic baud_pin
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // line_control_outputs: [0] rts, [1] dtr, [2] int enable, [3] cpu reset
  logic [3:0] lines_r;
  logic [3:0] lines_nxt;
  logic [3:0] flags;
  logic status_rd;
  logic [7:0] scratch_r;
  logic [7:0] scratch_nxt;
  logic [7:0] div_low_r;
  logic [7:0] div_low_nxt;
  logic [7:0] div_high_r;
  logic [7:0] div_high_nxt;
  logic div_wr;
  logic [7:0] host_rdata_r;
  logic [7:0] host_rdata_nxt;
  logic [7:0] mdm_rdata_r;
  logic [7:0] mdm_rdata_nxt;
  logic [3:0] ctl_out_n_r;
  logic [3:0] ctl_out_n_nxt;
  logic baud_pin_r;
  logic baud_pin_nxt;
  logic tick16;

  // ----------------------------------------------------------------
  // line state source
  // ----------------------------------------------------------------
  always_comb
  begin
    if (loop_mode)
    begin
      lines_nxt[ums_pkg::LINE_CTS] = line_control_outputs[0]; // [RULE3]
      lines_nxt[ums_pkg::LINE_DSR] = line_control_outputs[1]; // [RULE3]
      lines_nxt[ums_pkg::LINE_RI] = line_control_outputs[3]; // [RULE3]
      lines_nxt[ums_pkg::LINE_DCD] = line_control_outputs[2]; // [RULE3]
    end
    else if (standalone_select)
    begin
      lines_nxt = ~{dcd_n, ri_n, dsr_n, cts_n}; // [RULE1] [RULE19]
    end
    else
    begin
      lines_nxt = internal_line_bits; // [RULE1]
    end
    // outward controls held inactive in loop mode
    ctl_out_n_nxt = loop_mode ? ums_pkg::CTL_OUT_INACTIVE
                              : ~line_control_outputs; // [RULE19]
  end

  // ----------------------------------------------------------------
  // change flags
  // ----------------------------------------------------------------
  // flags are built by line position, so bits 0..3 follow cts, dsr, ri, dcd
  assign status_rd = host_rd &&
                     uart_address_lines == ums_pkg::ADDR_STATUS; // [RULE2]

  ums_change_flags u_flags
  (
    .clock(clock),
    .rst(rst),
    .cur(lines_r),
    .clear(status_rd),
    .flags(flags)
  );

  // ----------------------------------------------------------------
  // scratch, divisor latches
  // ----------------------------------------------------------------
  // on a same-cycle double write the modem bus lands last
  always_comb
  begin
    scratch_nxt = scratch_r;
    div_low_nxt = div_low_r;
    div_high_nxt = div_high_r;
    div_wr = 1'b0;
    if (host_wr)
    begin
      case (uart_address_lines)
        ums_pkg::ADDR_SCRATCH:
        begin
          scratch_nxt = host_wdata; // [RULE10] [RULE11]
        end
        ums_pkg::ADDR_DIV_LOW:
        begin
          if (divisor_access_bit)
          begin
            div_low_nxt = host_wdata; // [RULE12] [RULE13]
            div_wr = 1'b1; // [RULE17]
          end
        end
        ums_pkg::ADDR_DIV_HIGH:
        begin
          if (divisor_access_bit)
          begin
            div_high_nxt = host_wdata; // [RULE12] [RULE13]
            div_wr = 1'b1; // [RULE17]
          end
        end
        default:
        begin
          // status address and others: writes have no effect here
          scratch_nxt = scratch_r; // [RULE9]
        end
      endcase
    end
    if (mdm_scr_wr)
    begin
      scratch_nxt = mdm_wdata; // [RULE10] [RULE11]
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // divisor bytes are write only and read back as zero
  always_comb
  begin
    host_rdata_nxt = host_rdata_r;
    mdm_rdata_nxt = mdm_rdata_r;
    if (host_rd)
    begin
      case (uart_address_lines)
        ums_pkg::ADDR_STATUS:
        begin
          host_rdata_nxt = {lines_r, flags}; // [RULE4] [RULE5] [RULE6] [RULE7] [RULE8]
        end
        ums_pkg::ADDR_SCRATCH:
        begin
          host_rdata_nxt = scratch_r; // [RULE10]
        end
        default:
        begin
          host_rdata_nxt = ums_pkg::RDATA_RST; // [RULE13]
        end
      endcase
    end
    if (mdm_scr_rd)
    begin
      mdm_rdata_nxt = scratch_r; // [RULE10]
    end
  end

  // ----------------------------------------------------------------
  // baud generator
  // ----------------------------------------------------------------
  ums_baud_gen u_baud
  (
    .clock(clock),
    .rst(rst),
    .ref_tick(ref_tick),
    .divisor({div_high_r, div_low_r}),
    .reload(div_wr),
    .tick16(tick16)
  );

  always_comb
  begin
    baud_pin_nxt = tick16 & baud_pin_enable; // [RULE16]
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      lines_r <= ums_pkg::LINES_RST;
      scratch_r <= ums_pkg::SCRATCH_RST;
      div_low_r <= ums_pkg::DIV_LOW_RST;
      div_high_r <= ums_pkg::DIV_HIGH_RST;
      host_rdata_r <= ums_pkg::RDATA_RST;
      mdm_rdata_r <= ums_pkg::RDATA_RST;
      ctl_out_n_r <= ums_pkg::CTL_OUT_INACTIVE;
      baud_pin_r <= 1'b0;
      baud_tick16 <= 1'b0;
    end
    else
    begin
      lines_r <= lines_nxt;
      scratch_r <= scratch_nxt;
      div_low_r <= div_low_nxt;
      div_high_r <= div_high_nxt;
      host_rdata_r <= host_rdata_nxt;
      mdm_rdata_r <= mdm_rdata_nxt;
      ctl_out_n_r <= ctl_out_n_nxt;
      baud_pin_r <= baud_pin_nxt;
      baud_tick16 <= tick16; // [RULE15]
    end
  end

  assign host_rdata = host_rdata_r;
  assign mdm_rdata = mdm_rdata_r;
  assign ctl_out_n = ctl_out_n_r;
  assign baud_pin = baud_pin_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  standalone_pins_a: assert property ( // [RULE1]
    !loop_mode && standalone_select
    |=> lines_r == ~$past({dcd_n, ri_n, dsr_n, cts_n}))
    else $error("standalone line state not the inverted pins");
  internal_bits_a: assert property ( // [RULE1]
    !loop_mode && !standalone_select |=> lines_r == $past(internal_line_bits))
    else $error("line state not the internal bits");
  loop_feed_a: assert property ( // [RULE3]
    loop_mode |=> lines_r == {$past(line_control_outputs[2]),
                              $past(line_control_outputs[3]),
                              $past(line_control_outputs[1]),
                              $past(line_control_outputs[0])})
    else $error("loop mode line state wrong");
  loop_outputs_off_a: assert property ( // [RULE19]
    loop_mode |=> ctl_out_n == 4'hf)
    else $error("control outputs active in loop mode");
  status_read_data_a: assert property ( // [RULE8]
    status_rd |=> host_rdata[7:4] == $past(lines_r) &&
                  host_rdata[3:0] == $past(flags))
    else $error("status read returned wrong data");
  status_no_write_a: assert property ( // [RULE9]
    host_wr && !mdm_scr_wr && uart_address_lines == 3'h6
    |=> scratch_r == $past(scratch_r) && div_low_r == $past(div_low_r))
    else $error("write to status address changed state");
  scratch_last_write_a: assert property ( // [RULE11]
    mdm_scr_wr |=> scratch_r == $past(mdm_wdata))
    else $error("scratch did not keep the last write");
  modem_read_data_a: assert property ( // [RULE10]
    mdm_scr_rd |=> mdm_rdata == $past(scratch_r))
    else $error("modem read returned wrong scratch data");
  divisor_gate_a: assert property ( // [RULE12]
    host_wr && !divisor_access_bit |=> div_low_r == $past(div_low_r) &&
                                      div_high_r == $past(div_high_r))
    else $error("divisor written without divisor access");
  pin_gate_a: assert property ( // [RULE16]
    !baud_pin_enable |=> !baud_pin)
    else $error("baud pin driven while disabled");

  loop_seen_c: cover property (loop_mode ##1 status_rd);
  both_write_c: cover property (host_wr && mdm_scr_wr &&
                                uart_address_lines == 3'h7);
  baud_tick_c: cover property (baud_pin ##[1:200] baud_pin);
  read_with_change_c: cover property (status_rd && lines_nxt != lines_r);

endmodule

// ===== src/ums_pkg.sv
// package: addresses, bit positions, reset values and counts for the
// modem status, shared scratch and baud generator block.
// assumes: all users name items as ums_pkg::name, nothing is imported.
package ums_pkg;

  // ----------------------------------------------------------------
  // register addresses on the uart address lines
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_DIV_LOW = 3'h0;
  localparam logic [2:0] ADDR_DIV_HIGH = 3'h1;
  localparam logic [2:0] ADDR_STATUS = 3'h6;
  localparam logic [2:0] ADDR_SCRATCH = 3'h7;

  // ----------------------------------------------------------------
  // status register field positions
  // ----------------------------------------------------------------
  localparam int FLAG_LSB = 0;
  localparam int STATE_LSB = 4;
  localparam int LINE_CTS = 0;
  localparam int LINE_DSR = 1;
  localparam int LINE_RI = 2;
  localparam int LINE_DCD = 3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SCRATCH_RST = 8'h00;
  localparam logic [7:0] DIV_LOW_RST = 8'h00;
  localparam logic [7:0] DIV_HIGH_RST = 8'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;
  localparam logic [3:0] LINES_RST = 4'h0;
  localparam logic [3:0] CTL_OUT_INACTIVE = 4'hf;

  // ----------------------------------------------------------------
  // baud generator
  // ----------------------------------------------------------------
  localparam int REF_HZ = 1843200;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;

endpackage

// ===== src/ums_change_flags.sv
// holds the four change flags of the modem status register.
// assumes: cur is registered in the caller; clear is the one-cycle
// status read strobe.
`timescale 1ns/1ns
module ums_change_flags
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // line states and read strobe
  input wire logic [3:0] cur,
  input wire logic clear,
  // change flags
  output logic [3:0] flags
);

  logic [3:0] prev_r;
  logic [3:0] prev_nxt;
  logic [3:0] flag_r;
  logic [3:0] flag_nxt;
  logic primed_r;
  logic primed_nxt;

  // ----------------------------------------------------------------
  // per-line change detect
  // ----------------------------------------------------------------
  // first cycle after reset only loads prev, so no false change
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_line
      always_comb
      begin
        flag_nxt[gi] = (flag_r[gi] & ~clear) |
                       (primed_r & (cur[gi] != prev_r[gi])); // [RULE2] [RULE20]
      end
    end
  endgenerate

  always_comb
  begin
    prev_nxt = cur;
    primed_nxt = 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      prev_r <= ums_pkg::LINES_RST;
      flag_r <= ums_pkg::LINES_RST;
      primed_r <= 1'b0;
    end
    else
    begin
      prev_r <= prev_nxt;
      flag_r <= flag_nxt;
      primed_r <= primed_nxt;
    end
  end

  assign flags = flag_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  change_sets_flag_a: assert property ( // [RULE2]
    primed_r && (cur != prev_r) |=> ((flags & $past(cur ^ prev_r)) ==
                                     $past(cur ^ prev_r)))
    else $error("line change did not set its flag");
  quiet_read_clears_a: assert property ( // [RULE20]
    clear && primed_r && (cur == prev_r) |=> flags == 4'h0)
    else $error("read without change left a flag set");
  flag_holds_a: assert property ( // [RULE2]
    !clear && (flag_r != 4'h0) |=> (flags & $past(flag_r)) == $past(flag_r))
    else $error("flag dropped without a read");

endmodule

// ===== src/ums_baud_gen.sv
// programmable baud generator: divides the reference tick by a 16-bit
// divisor and pulses once per divided period (16x the data rate).
// assumes: ref_tick is a one-cycle pulse at the 1.8432 MHz reference rate.
`timescale 1ns/1ns
module ums_baud_gen
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // reference and divisor
  input wire logic ref_tick,
  input wire logic [15:0] divisor,
  input wire logic reload,
  // output
  output logic tick16
);

  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic tick_r;
  logic tick_nxt;

  // ----------------------------------------------------------------
  // down-counter
  // ----------------------------------------------------------------
  // a zero divisor stops the output rather than counting 65536
  always_comb
  begin
    count_nxt = count_r;
    tick_nxt = 1'b0;
    if (reload)
    begin
      count_nxt = divisor; // [RULE17]
    end
    else if (ref_tick && divisor != ums_pkg::COUNT_ZERO)
    begin
      if (count_r <= ums_pkg::COUNT_ONE)
      begin
        count_nxt = divisor; // [RULE14]
        tick_nxt = 1'b1; // [RULE15]
      end
      else
      begin
        count_nxt = count_r - ums_pkg::COUNT_ONE;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      count_r <= ums_pkg::COUNT_ZERO;
      tick_r <= 1'b0;
    end
    else
    begin
      count_r <= count_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick16 = tick_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  reload_loads_count_a: assert property ( // [RULE17]
    reload |=> count_r == $past(divisor))
    else $error("divisor write did not reload the counter");
  tick_at_terminal_a: assert property ( // [RULE14]
    !reload && ref_tick && divisor != 16'h0000 && count_r <= 16'h0001
    |=> tick_r && count_r == $past(divisor))
    else $error("terminal count gave no tick");
  no_tick_without_ref_a: assert property ( // [RULE15]
    !ref_tick |=> !tick_r)
    else $error("tick without a reference tick");

endmodule

// ===== verif/ums_bus_model.sv
// model of the host uart bus, the modem scratch bus and the reference tick.
// assumes: drives on the falling edge; the design samples on the rising one.
`timescale 1ns/1ns
module ums_bus_model
(
  // clock
  input wire logic clock,
  // host bus
  output logic [2:0] addr,
  output logic hrd,
  output logic hwr,
  output logic [7:0] hwd,
  input wire logic [7:0] hrdata,
  // modem bus
  output logic mrd,
  output logic mwr,
  output logic [7:0] mwd,
  input wire logic [7:0] mrdata,
  // reference
  output logic ref_tick
);
  // ----------------------------------------------------------------
  // strobes and reference tick
  // ----------------------------------------------------------------
  int ref_gap = 1;
  int rc = 0;

  initial
  begin
    {addr, hrd, hwr, hwd, mrd, mwr, mwd} = '0;
    ref_tick = 1'b0;
  end

  // gap of 1 ticks every cycle; larger gaps slow the reference
  always @(negedge clock)
  begin
    rc = (rc + 1 >= ref_gap) ? 0 : rc + 1;
    ref_tick = (rc == 0);
  end

  task automatic hw(input logic [2:0] a, input logic [7:0] d);
    @(negedge clock);
    addr = a;
    hwd = d;
    hwr = 1'b1;
    @(negedge clock);
    hwr = 1'b0;
    // released data no longer shows the written value
    hwd = ~d;
  endtask

  task automatic hr(input logic [2:0] a, output logic [7:0] d);
    @(negedge clock);
    addr = a;
    hrd = 1'b1;
    @(negedge clock);
    hrd = 1'b0;
    d = hrdata;
  endtask

  task automatic mw(input logic [7:0] d);
    @(negedge clock);
    mwd = d;
    mwr = 1'b1;
    @(negedge clock);
    mwr = 1'b0;
    mwd = ~d;
  endtask

  task automatic mr(output logic [7:0] d);
    @(negedge clock);
    mrd = 1'b1;
    @(negedge clock);
    mrd = 1'b0;
    d = mrdata;
  endtask

  // both processors write the scratch in the same cycle
  task automatic both(input logic [7:0] h, input logic [7:0] m);
    fork
      hw(ums_pkg::ADDR_SCRATCH, h);
      mw(m);
    join
  endtask
endmodule

// ===== verif/uart_modem_status_scratch_baud_bench.sv
// self-checking bench for the modem status, scratch and baud block.
// assumes: ums_bus_model drives both buses; pins and control bits here.
`timescale 1ns/1ns
module uart_modem_status_scratch_baud_bench;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [2:0] addr;
  logic hrd, hwr, mrd, mwr, ref_tick, tick16, bpin;
  logic [7:0] hwd, mwd, hrdata, mrdata, d, d2, v;
  logic dab = 1'b0;
  logic sas = 1'b0;
  logic loop = 1'b0;
  logic bpe = 1'b0;
  logic [3:0] lco = 4'h0;
  logic [3:0] ilb = 4'h0;
  logic [3:0] pins = 4'hf;
  logic [3:0] last = 4'h0;
  logic [3:0] ctl_n;
  logic [15:0] dv;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int w, p;
  int rates[3] = '{2304, 384, 96};

  always #20 clock = ~clock;

  ums_bus_model bm (.clock(clock), .addr(addr), .hrd(hrd), .hwr(hwr),
    .hwd(hwd), .hrdata(hrdata), .mrd(mrd), .mwr(mwr), .mwd(mwd),
    .mrdata(mrdata), .ref_tick(ref_tick));

  ums_top DUT (.clock(clock), .rst(rst), .uart_address_lines(addr),
    .host_rd(hrd), .host_wr(hwr), .host_wdata(hwd), .host_rdata(hrdata),
    .mdm_scr_rd(mrd), .mdm_scr_wr(mwr), .mdm_wdata(mwd),
    .mdm_rdata(mrdata), .divisor_access_bit(dab), .standalone_select(sas),
    .loop_mode(loop), .line_control_outputs(lco),
    .internal_line_bits(ilb), .baud_pin_enable(bpe), .cts_n(pins[0]),
    .dsr_n(pins[1]), .ri_n(pins[2]), .dcd_n(pins[3]), .ctl_out_n(ctl_n),
    .ref_tick(ref_tick), .baud_tick16(tick16), .baud_pin(bpin));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("errors %0d checks %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // loop wiring: cts<-rts, dsr<-dtr, ri<-local reset, dcd<-int enable
  function automatic logic [3:0] exp_lines();
    if (loop)
      return {lco[2], lco[3], lco[1], lco[0]};
    return sas ? ~pins : ilb;
  endfunction

  // flags are the xor with the last read only while one change is pending
  task automatic rd_status;
    logic [3:0] l;
    l = exp_lines();
    repeat (3) @(negedge clock);
    bm.hr(ums_pkg::ADDR_STATUS, d);
    check(16'(d), 16'({l, l ^ last}));
    last = l;
  endtask

  // w: cycles to the first pulse, p: cycles between two pulses
  // the settle skips a pulse still in flight from the old divisor
  task automatic period;
    repeat (2) @(negedge clock);
    w = 0;
    while (tick16 !== 1'b1 && w < 5000)
    begin
      @(negedge clock);
      w++;
    end
    p = 0;
    do
    begin
      @(negedge clock);
      p++;
    end while (tick16 !== 1'b1 && p < 5000);
  endtask

  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_errors++;
      print_verdict;
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h3d31));
    repeat (6) @(negedge clock);
    rst = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      v = 8'($urandom);
      bm.hw(ums_pkg::ADDR_SCRATCH, v);
      bm.mr(d);
      check(16'(d), 16'(v));
      bm.mw(~v);
      bm.hr(ums_pkg::ADDR_SCRATCH, d);
      check(16'(d), 16'({8'h00, ~v}));
    end
    bm.both(8'h5a, 8'ha5);
    bm.hr(ums_pkg::ADDR_SCRATCH, d);
    check(16'(d), 16'h00a5);
    for (int i = 0; i < 8; i++)
    begin
      sas = i[0];
      loop = (i > 5);
      ilb = 4'($urandom);
      pins = 4'($urandom);
      lco = 4'($urandom);
      rd_status();
      rd_status();
      check(16'(ctl_n), 16'({12'h000, loop ? 4'hf : ~lco}));
    end
    bm.hw(ums_pkg::ADDR_STATUS, 8'hff);
    rd_status();
    // a line change landing with the read must survive into the next one
    loop = 1'b0;
    sas = 1'b0;
    ilb = last;
    rd_status();
    // flipped one cycle ahead, so the detector sees it on the read edge
    ilb = ~ilb;
    bm.hr(ums_pkg::ADDR_STATUS, d2);
    check(16'(d2), 16'({ilb, 4'h0}));
    rd_status();
    // divisor access set before any divisor write
    dab = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      dv = 16'($urandom_range(9, 2));
      bm.ref_gap = 1 + i[0];
      bpe = i[1];
      bm.hw(ums_pkg::ADDR_DIV_HIGH, dv[15:8]);
      bm.hw(ums_pkg::ADDR_DIV_LOW, dv[7:0]);
      period();
      check(16'(p), dv * 16'(bm.ref_gap));
      check(16'(bpin), 16'(bpe));
    end
    bm.hr(ums_pkg::ADDR_DIV_LOW, d);
    check(16'(d), 16'h0000);
    bm.ref_gap = 1;
    foreach (rates[i])
    begin
      bm.hw(ums_pkg::ADDR_DIV_HIGH, rates[i][15:8]);
      bm.hw(ums_pkg::ADDR_DIV_LOW, rates[i][7:0]);
      period();
      check(16'(p), 16'(rates[i]));
    end
    // divisor 96 then 3: the new count must start at once
    bm.hw(ums_pkg::ADDR_DIV_LOW, 8'h03);
    bm.hw(ums_pkg::ADDR_DIV_HIGH, 8'h00);
    period();
    check(16'(w <= 6), 16'h0001);
    check(16'(p), 16'h0003);
    dab = 1'b0;
    bm.hw(ums_pkg::ADDR_DIV_LOW, 8'h07);
    period();
    check(16'(p), 16'h0003);
    print_verdict;
  end
endmodule
